// >>> inc/dfc_pkg.sv
// Shared constants, types and helpers of the decimation filter chain
`default_nettype none
package dfc_pkg;
	// Clock, modulator and over-range timing
	localparam int CLK_HZ = 25_000_000;
	localparam int MOD_DIV = 4;
	localparam int OVR_DIV = 2;
	localparam int OVR_CLKS = MOD_DIV * OVR_DIV;
	// Settling counts in output words
	localparam int LINEAR_N = 31;
	localparam int SETTLE_N = 62;
	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_HPC = 8'h04;
	localparam logic [7:0] A_DATA = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	// Field positions
	localparam int CTRL_FSEL_LSB = 0;
	localparam int CTRL_RATE_LSB = 2;
	localparam int CTRL_PHS_BIT = 5;
	localparam int ST_FLAG = 0;
	localparam int ST_NEW = 1;
	localparam int ST_LIN = 2;
	localparam int ST_SET = 3;
	// Arithmetic
	localparam int SINC_W = 38;
	localparam int SINC_NORM = 30;
	localparam int MAX_RATE = 4;
	localparam int FIR_TAPS = 8;
	localparam int FIR_SH = 5;
	localparam int HPF_SH = 16;
	localparam logic signed [31:0] FS_POS = 32'sh7FFFFFFF;
	localparam logic signed [31:0] FS_NEG = 32'sh80000000;
	// Coefficients, tap 0 in the low byte, each set sums to 32
	localparam logic [63:0] HB_C = 64'h00FF0009100900FF;
	localparam logic [63:0] S3_LIN = 64'h0102040909040201;
	localparam logic [63:0] S3_MIN = 64'h0001010204060909;
	localparam logic [63:0] S4_LIN = 64'h0001030808080301;
	localparam logic [63:0] S4_MIN = 64'h000001020306080C;
	typedef struct packed {
		logic vld;
		logic signed [31:0] dat;
	} dfc_smp_t;
	typedef struct packed {
		logic [1:0] fsel;
		logic [2:0] rate;
		logic phase_select;
	} dfc_cfg_t;
	localparam dfc_cfg_t CFG_RST = '{fsel: 2'h2, rate: 3'h0, phase_select: 1'b0};
	localparam logic [15:0] HPC_RST = 16'h0337;
	function automatic logic signed [31:0] dfc_sat32(input logic signed [47:0] v);
		if (v > 48'(FS_POS)) begin
			return FS_POS;
		end else if (v < 48'(FS_NEG)) begin
			return FS_NEG;
		end
		return v[31:0];
	endfunction
endpackage
`default_nettype wire

// >>> hw/dfc_sinc.sv
// Fifth-order decimating sinc stage
`default_nettype none
module dfc_sinc import dfc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic clr,
	input wire logic [2:0] rate,
	// Modulator stream
	input wire logic mod_tick,
	input wire logic mod_bit,
	// Decimated words
	output dfc_smp_t smp
);
	logic signed [SINC_W-1:0] ig_r [1:5];
	logic signed [SINC_W-1:0] ig_src [0:4];
	logic signed [SINC_W-1:0] cd [0:5];
	logic signed [SINC_W-1:0] dl_r [0:4];
	logic [6:0] cnt_r;
	logic [2:0] k;
	logic dec;
	logic signed [SINC_W+SINC_NORM-1:0] wide;

	// Codes above the fastest rate fall back to it
	assign k = 3'(7 - ((rate > 3'(MAX_RATE)) ? 3'(MAX_RATE) : rate));
	assign dec = mod_tick && (cnt_r == 7'((1 << k) - 1));
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else if (clr || dec) begin
			cnt_r <= '0;
		end else if (mod_tick) begin
			cnt_r <= cnt_r + 7'h01;
		end
	end

	// Integrators wrap; the combs undo the wrap exactly
	assign cd[0] = ig_r[5];
	for (genvar g = 0; g < 5; g++) begin : g_st
		// First integrator takes the bit as +1 or -1
		assign ig_src[g] = (g == 0) ? (mod_bit ? SINC_W'(1) : -SINC_W'(1))
			: ig_r[(g == 0) ? 1 : g];
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				ig_r[g+1] <= '0;
				dl_r[g] <= '0;
			end else if (clr) begin
				ig_r[g+1] <= '0;
				dl_r[g] <= '0;
			end else begin
				if (mod_tick) begin
					ig_r[g+1] <= ig_r[g+1] + ig_src[g];
				end
				if (dec) begin
					dl_r[g] <= cd[g];
				end
			end
		end
		assign cd[g+1] = cd[g] - dl_r[g];
	end

	// Divide by N^5 and place full scale at 2^30
	assign wide = (SINC_W+SINC_NORM)'(cd[5]) <<< SINC_NORM >>> (5 * k);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			smp <= '0;
		end else begin
			smp.vld <= dec && !clr;
			if (dec) begin
				smp.dat <= wide[31:0];
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/dfc_fir.sv
// One decimating FIR sub-stage with two coefficient sets
`default_nettype none
module dfc_fir import dfc_pkg::*; #(
	parameter int DEC = 2,
	parameter logic [63:0] CA = HB_C,
	parameter logic [63:0] CB = HB_C
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic clr,
	input wire logic phase_select,
	// Stream
	input wire dfc_smp_t din,
	output dfc_smp_t dout
);
	logic signed [31:0] x_r [0:FIR_TAPS-1];
	logic [1:0] cnt_r;
	logic fire_r;
	logic [63:0] cf;
	logic signed [47:0] acc;

	assign cf = phase_select ? CB : CA;

	always_comb begin
		acc = '0;
		for (int i = 0; i < FIR_TAPS; i++) begin
			acc = acc + 48'($signed(cf[8*i +: 8])) * 48'(x_r[i]);
		end
	end

	for (genvar g = 0; g < FIR_TAPS; g++) begin : g_tap
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				x_r[g] <= '0;
			end else if (clr) begin
				x_r[g] <= '0;
			end else if (din.vld) begin
				x_r[g] <= (g == 0) ? din.dat : x_r[(g == 0) ? 0 : g-1];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
			fire_r <= 1'b0;
			dout <= '0;
		end else if (clr) begin
			cnt_r <= '0;
			fire_r <= 1'b0;
			dout.vld <= 1'b0;
		end else begin
			if (din.vld) begin
				cnt_r <= (cnt_r == 2'(DEC - 1)) ? 2'h0 : cnt_r + 2'h1;
			end
			fire_r <= din.vld && (cnt_r == 2'(DEC - 1));
			dout.vld <= fire_r;
			if (fire_r) begin
				dout.dat <= dfc_sat32(acc >>> FIR_SH);
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/dfc_top.sv
// Decimation filter chain with over-range flag and AHB-Lite registers
//
// Behaviour
// - Flag high while input exceeds full scale
// - Flag sampled at half the modulator rate
// - Flag pulse lasts one sample period minimum
// - Modulator rate is clock divided by four
// - Sinc, then FIR, then high-pass cascade
// - Filter select picks bypass, sinc, FIR, high-pass
// - Sinc is scaled fifth-order comb response
// - Rate code sets sinc decimation 128 to 8
// - Sinc nulls at output rate and multiples
// - FIR sub-stages decimate 2, 2, 4, 2
// - Total decimation 4096 down to 256
// - Last two sub-stages hold two coefficient sets
// - Phase bit: 0 linear, 1 minimum
// - FIR passband flat to 0.375 output rate
// - Final stage is first-order recursive high-pass
// - High-pass corner is 16-bit coefficient
// - Bypass shuts the decimating filters down
// - Linear after 31 outputs, settled after 62
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module dfc_top import dfc_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Analog modulator side
	input wire logic MOD_BIT,
	input wire logic OVR_CMP,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Conversion output
	output logic signed [31:0] DATA_OUT,
	output logic DATA_READY,
	output logic OVERRANGE_FLAG
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic mb_s1_r;
	logic mb_s2_r;
	logic ov_s1_r;
	logic ov_s2_r;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mb_s1_r <= 1'b0;
			mb_s2_r <= 1'b0;
			ov_s1_r <= 1'b0;
			ov_s2_r <= 1'b0;
		end else begin
			mb_s1_r <= MOD_BIT;
			mb_s2_r <= mb_s1_r;
			ov_s1_r <= OVR_CMP;
			ov_s2_r <= ov_s1_r;
		end
	end

	// ****************************************
	// Modulator and over-range timing
	// ****************************************
	logic [2:0] div_r;
	logic mod_tick;
	logic ovr_tick;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 3'h1;
		end
	end

	assign mod_tick = (div_r[1:0] == 2'(MOD_DIV - 1));
	assign ovr_tick = (div_r == 3'(OVR_CLKS - 1));

	// Holding between ticks also gives the minimum pulse width
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			OVERRANGE_FLAG <= 1'b0;
		end else if (ovr_tick) begin
			OVERRANGE_FLAG <= ov_s2_r;
		end
	end

	// ****************************************
	// Configuration
	// ****************************************
	dfc_cfg_t cfg_r;
	logic [15:0] hpc_r;
	logic clr_r;
	logic wp_r;
	logic [7:0] wa_r;
	logic ap;
	dfc_cfg_t cfg_nxt;

	assign ap = HSEL && HTRANS[1] && HREADY;
	assign cfg_nxt = '{fsel: HWDATA[CTRL_FSEL_LSB +: 2],
		rate: HWDATA[CTRL_RATE_LSB +: 3], phase_select: HWDATA[CTRL_PHS_BIT]};

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wp_r <= 1'b0;
			wa_r <= '0;
		end else begin
			wp_r <= ap && HWRITE;
			wa_r <= HADDR[7:0];
		end
	end

	// A changed CTRL setting restarts the chain so stale words never mix in; an HPC write does not restart it
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_r <= CFG_RST;
			hpc_r <= HPC_RST;
			clr_r <= 1'b0;
		end else begin
			clr_r <= 1'b0;
			if (wp_r && wa_r == A_CTRL) begin
				cfg_r <= cfg_nxt;
				clr_r <= (cfg_nxt != cfg_r);
			end
			if (wp_r && wa_r == A_HPC) begin
				hpc_r <= HWDATA[15:0];
			end
		end
	end

	// ****************************************
	// Filter cascade
	// ****************************************
	dfc_smp_t sinc_o;
	dfc_smp_t hb1_o;
	dfc_smp_t hb2_o;
	dfc_smp_t s3_o;
	dfc_smp_t fir_o;
	logic clr_sinc;
	logic clr_fir;
	logic clr_hp;

	assign clr_sinc = clr_r || (cfg_r.fsel == 2'h0);
	assign clr_fir = clr_r || (cfg_r.fsel < 2'h2);
	assign clr_hp = clr_r || (cfg_r.fsel != 2'h3);

	dfc_sinc u_sinc (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(clr_sinc),
		.rate(cfg_r.rate),
		.mod_tick(mod_tick),
		.mod_bit(mb_s2_r),
		.smp(sinc_o)
	);

	dfc_fir #(.DEC(2), .CA(HB_C), .CB(HB_C)) u_hb1 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(clr_fir),
		.phase_select(cfg_r.phase_select),
		.din(sinc_o),
		.dout(hb1_o)
	);

	dfc_fir #(.DEC(2), .CA(HB_C), .CB(HB_C)) u_hb2 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(clr_fir),
		.phase_select(cfg_r.phase_select),
		.din(hb1_o),
		.dout(hb2_o)
	);

	dfc_fir #(.DEC(4), .CA(S3_LIN), .CB(S3_MIN)) u_s3 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(clr_fir),
		.phase_select(cfg_r.phase_select),
		.din(hb2_o),
		.dout(s3_o)
	);

	dfc_fir #(.DEC(2), .CA(S4_LIN), .CB(S4_MIN)) u_s4 (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(clr_fir),
		.phase_select(cfg_r.phase_select),
		.din(s3_o),
		.dout(fir_o)
	);

	// ****************************************
	// High-pass stage
	// ****************************************
	logic signed [31:0] hx_r;
	logic signed [31:0] hy_r;
	logic hp_vld_r;
	logic signed [48:0] hp_prod;
	logic signed [47:0] hp_sum;

	// y = x - x' + y' - y' * coef / 65536
	assign hp_prod = hy_r * $signed({1'b0, hpc_r});
	assign hp_sum = 48'(fir_o.dat) - 48'(hx_r) + 48'(hy_r)
		- 48'($signed(hp_prod[48:HPF_SH]));

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hx_r <= '0;
			hy_r <= '0;
			hp_vld_r <= 1'b0;
		end else if (clr_hp) begin
			hx_r <= '0;
			hy_r <= '0;
			hp_vld_r <= 1'b0;
		end else begin
			hp_vld_r <= fir_o.vld;
			if (fir_o.vld) begin
				hx_r <= fir_o.dat;
				hy_r <= dfc_sat32(hp_sum);
			end
		end
	end

	// ****************************************
	// Output selection
	// ****************************************
	logic sel_vld;
	logic signed [31:0] sel_dat;

	always_comb begin
		sel_vld = 1'b0;
		sel_dat = '0;
		case (cfg_r.fsel)
			2'h0: begin
				sel_vld = mod_tick;
				sel_dat = mb_s2_r ? FS_POS : FS_NEG;
			end
			2'h1: begin
				sel_vld = sinc_o.vld;
				sel_dat = sinc_o.dat;
			end
			2'h2: begin
				sel_vld = fir_o.vld;
				sel_dat = fir_o.dat;
			end
			default: begin
				sel_vld = hp_vld_r;
				sel_dat = hy_r;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			DATA_OUT <= '0;
			DATA_READY <= 1'b0;
		end else begin
			DATA_READY <= sel_vld && !clr_r;
			if (sel_vld) begin
				DATA_OUT <= sel_dat;
			end
		end
	end

	// ****************************************
	// Settling count and status
	// ****************************************
	logic [5:0] out_cnt_r;
	logic new_r;
	logic data_rd;

	assign data_rd = ap && !HWRITE && (HADDR[7:0] == A_DATA);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_cnt_r <= '0;
		end else if (clr_r) begin
			out_cnt_r <= '0;
		end else if (sel_vld && out_cnt_r < 6'(SETTLE_N)) begin
			out_cnt_r <= out_cnt_r + 6'h01;
		end
	end

	// A new word arriving with the read keeps the flag set
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			new_r <= 1'b0;
		end else if (DATA_READY) begin
			new_r <= 1'b1;
		end else if (data_rd) begin
			new_r <= 1'b0;
		end
	end

	// ****************************************
	// AHB-Lite read side, zero wait states
	// ****************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = '0;
		case (HADDR[7:0])
			A_CTRL: begin
				rd_val[CTRL_FSEL_LSB +: 2] = cfg_r.fsel;
				rd_val[CTRL_RATE_LSB +: 3] = cfg_r.rate;
				rd_val[CTRL_PHS_BIT] = cfg_r.phase_select;
			end
			A_HPC: rd_val[15:0] = hpc_r;
			A_DATA: rd_val = DATA_OUT;
			A_STAT: begin
				rd_val[ST_FLAG] = OVERRANGE_FLAG;
				rd_val[ST_NEW] = new_r;
				rd_val[ST_LIN] = (out_cnt_r >= 6'(LINEAR_N));
				rd_val[ST_SET] = (out_cnt_r >= 6'(SETTLE_N));
			end
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			if (ap && !HWRITE) begin
				HRDATA <= rd_val;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence s_mod_gap;
		!mod_tick [*3] ##1 mod_tick;
	endsequence

	sequence s_flag_hold;
		OVERRANGE_FLAG [*8];
	endsequence

	a_flag_track: assert property (ovr_tick |=> OVERRANGE_FLAG == $past(ov_s2_r))
		else $error("flag does not follow comparator");
	a_flag_instant: assert property ($changed(OVERRANGE_FLAG) |-> $past(ovr_tick))
		else $error("flag moved off a sample instant");
	a_flag_width: assert property ($rose(OVERRANGE_FLAG) |-> s_flag_hold)
		else $error("flag pulse too short");
	a_mod_divide: assert property (mod_tick |=> s_mod_gap)
		else $error("modulator tick not every four clocks");
	a_sinc_spacing: assert property (sinc_o.vld |=> !sinc_o.vld [*7])
		else $error("sinc words too close");
	a_bypass_idle: assert property (cfg_r.fsel == 2'h0 [*2] |-> !sinc_o.vld && !fir_o.vld)
		else $error("filters run in bypass");
	a_fir_route: assert property (cfg_r.fsel == 2'h2 && fir_o.vld && !clr_r
		|=> DATA_READY && DATA_OUT == $past(fir_o.dat))
		else $error("FIR word not routed to output");
	a_ready_pulse: assert property (DATA_READY |=> !DATA_READY)
		else $error("ready strobe longer than a cycle");
	a_settle_count: assert property ($rose(out_cnt_r == 6'(SETTLE_N))
		|-> $past(out_cnt_r) == 6'(SETTLE_N - 1))
		else $error("settle count skipped");
endmodule
`default_nettype wire

// >>> tb/dfc_mod_model.sv
// Behavioural modulator: bit stream and over-range comparator
`default_nettype none
module dfc_mod_model (
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic [1:0] mode,
	input wire logic ovr_req,
	// Device pins
	output logic mod_bit,
	output logic ovr_cmp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		mod_bit = 1'b0;
		ovr_cmp = 1'b0;
	end
	// Mode 0 all zeros, 1 all ones, 2 random density; a real stream never idles
	always @(posedge clk) begin
		mod_bit <= (mode == 2'h2) ? 1'($urandom) : mode[0];
		ovr_cmp <= ovr_req;
	end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the decimation filter chain
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module testbench import dfc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK, RST_B, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS, mode;
	logic [2:0] HSIZE;
	logic DATA_READY, OVERRANGE_FLAG, MOD_BIT, OVR_CMP, ovr_req, flag_d;
	logic signed [31:0] DATA_OUT, word;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int last_chg = -1;
	assign HREADY = HREADYOUT;
	dfc_top u_dut (.CLK(CLK), .RST_B(RST_B), .MOD_BIT(MOD_BIT), .OVR_CMP(OVR_CMP),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .DATA_OUT(DATA_OUT), .DATA_READY(DATA_READY),
		.OVERRANGE_FLAG(OVERRANGE_FLAG));
	dfc_mod_model u_mod (.clk(CLK), .mode(mode), .ovr_req(ovr_req), .mod_bit(MOD_BIT),
		.ovr_cmp(OVR_CMP));
	initial begin
		CLK = 1'b0;
		flag_d = 1'b0;
	end
	always #20 CLK = ~CLK;
	// ****************************************
	// Helpers
	// ****************************************
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Whole run needs about 13k cycles; the ceiling leaves plenty of slack
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			$display("CHECK FAILED t=%0t bench timeout", $time);
			tally_and_finish();
		end
	end
	// Flag edges must sit on the sampling grid and pulses span a full sample
	always @(posedge CLK) begin
		flag_d <= OVERRANGE_FLAG;
		if (RST_B === 1'b1 && OVERRANGE_FLAG !== flag_d) begin
			if (last_chg >= 0) begin
				`CHK((cyc - last_chg) % OVR_CLKS, 0)
				if (OVERRANGE_FLAG !== 1'b1) begin
					`CHK(cyc - last_chg >= OVR_CLKS, 1'b1)
				end
			end
			last_chg <= cyc;
		end
	end
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		HSEL <= 1'b1;
		HADDR <= a;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HSIZE <= 3'h2;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		q = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, 32'(a), d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, 32'(a), 32'h00000000, q);
	endtask
	task automatic set_ctrl(input logic [1:0] f, input logic [2:0] r, input logic p);
		wr(A_CTRL, {26'h0000000, p, r, f});
		// Skip a word the old setting may launch at the write edge
		@(posedge CLK);
	endtask
	task automatic next_word(output int c);
		c = 0;
		do begin
			@(posedge CLK);
			c++;
		end while (DATA_READY !== 1'b1 && c < 40000);
		word = DATA_OUT;
	endtask
	task automatic check_gap(input int exp);
		int c;
		next_word(c);
		next_word(c);
		`CHK(c, exp)
	endtask
	function automatic int sinc_n(input logic [2:0] r);
		return (r > 3'h4) ? 8 : (128 >> r);
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] q;
		logic [15:0] h;
		logic [2:0] r;
		int c;
		RST_B = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h00000000;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h00000000;
		mode = 2'h0;
		ovr_req = 1'b0;
		void'($urandom(32'h7402DDE1));
		repeat (2) @(posedge CLK);
		`CHK({HREADYOUT, HRESP, DATA_READY, OVERRANGE_FLAG, DATA_OUT}, {4'h8, 32'h0})
		RST_B <= 1'b1;
		@(posedge CLK);
		rd(A_CTRL, q);
		`CHK(q, 32'h00000002)
		rd(A_HPC, q);
		`CHK(q, {16'h0000, HPC_RST})
		h = 16'($urandom);
		wr(A_HPC, {16'hFFFF, h});
		rd(A_HPC, q);
		`CHK(q, {16'h0000, h})
		wr(8'h1C, 32'hFFFFFFFF);
		rd(8'h1C, q);
		`CHK(q, 32'h00000000)
		$display("Test registers done");
		mode <= 2'h1;
		set_ctrl(2'h0, 3'h0, 1'b0);
		repeat (16) @(posedge CLK);
		next_word(c);
		`CHK(word, FS_POS)
		check_gap(MOD_DIV);
		mode <= 2'h0;
		repeat (16) @(posedge CLK);
		next_word(c);
		`CHK(word, FS_NEG)
		$display("Test bypass done");
		mode <= 2'h2;
		for (int i = 0; i < 6; i++) begin
			r = (i < 5) ? 3'(i) : 3'($urandom_range(7, 5));
			set_ctrl(2'h1, r, 1'b0);
			check_gap(MOD_DIV * sinc_n(r));
		end
		mode <= 2'h1;
		repeat (10) next_word(c);
		`CHK(word, 32'sh40000000)
		$display("Test sinc done");
		mode <= 2'h2;
		set_ctrl(2'h1, 3'h4, 1'b0);
		for (int k = 1; k <= SETTLE_N; k++) begin
			next_word(c);
			if (k == LINEAR_N - 1 || k == LINEAR_N || k == SETTLE_N) begin
				rd(A_STAT, q);
				`CHK(q[3:0], {k == SETTLE_N, k >= LINEAR_N, 2'b10})
				rd(A_DATA, q);
				`CHK(q, word)
				rd(A_STAT, q);
				`CHK(q[1], 1'b0)
			end
		end
		$display("Test settling done");
		set_ctrl(2'h2, 3'h4, 1'b0);
		check_gap(MOD_DIV * 256);
		set_ctrl(2'h2, 3'h3, 1'b1);
		check_gap(MOD_DIV * 16 * 32);
		rd(A_CTRL, q);
		`CHK(q, 32'h0000002E)
		set_ctrl(2'h3, 3'h4, 1'b0);
		check_gap(MOD_DIV * 8 * 32);
		$display("Test FIR and high-pass done");
		@(posedge CLK);
		ovr_req <= 1'b1;
		c = 0;
		while (OVERRANGE_FLAG !== 1'b1 && c < 13) begin
			@(posedge CLK);
			c++;
		end
		`CHK(OVERRANGE_FLAG, 1'b1)
		rd(A_STAT, q);
		`CHK(q[0], 1'b1)
		repeat (20) @(posedge CLK);
		ovr_req <= 1'b0;
		repeat (13) @(posedge CLK);
		`CHK(OVERRANGE_FLAG, 1'b0)
		repeat (20) begin
			ovr_req <= 1'b1;
			repeat ($urandom_range(3, 1)) @(posedge CLK);
			ovr_req <= 1'b0;
			repeat ($urandom_range(20, 1)) @(posedge CLK);
		end
		repeat (16) @(posedge CLK);
		$display("Test over-range done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
